// File: rtl/cbo_map.svh
`ifndef CBO_MAP_SVH
`define CBO_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CBO_OFF_SYNC      8'h3d
`define CBO_OFF_PLL_TRIGGER_A    8'h3e
`define CBO_OFF_BIASCAL   8'h3f
`define CBO_OFF_ENABLES   8'h40
`define CBO_OFF_BANKD     8'h41

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CBO_CMD_BIT       7
`define CBO_EN_A_BIT      3
`define CBO_EN_B_BIT      2
`define CBO_EN_C_BIT      1
`define CBO_EN_D_BIT      0
`define CBO_BD_DIV_BIT    0
`define CBO_BD_SRC_BIT    1
`define CBO_BD_PD_BIT     2
`define CBO_BD_OWN_BIT    3
`define CBO_BD_OPD_BIT    4
`define CBO_BD_STY_BIT    5
`define CBO_BD_AMP_LO     6

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define CBO_RST_ENABLES   4'hf
`define CBO_RST_BANKD     8'h00
`define CBO_SYNC_CYC      16'h0010
`define CBO_PLL_TRIGGER_A_CYC    16'h0100
`define CBO_CAL_CYC       16'h0040

`endif

// File: rtl/cbo_pkg.sv
package cbo_pkg;
	typedef enum logic [1:0] {
		CBO_SWING_350MV = 2'h0,
		CBO_SWING_500MV = 2'h1,
		CBO_SWING_750MV = 2'h2,
		CBO_SWING_RSVD  = 2'h3
	} cbo_swing_t;

	typedef enum logic [1:0] {
		CBO_CMD_IDLE = 2'h1,
		CBO_CMD_BUSY = 2'h2
	} cbo_cmd_state_t;
endpackage

// File: rtl/cbo_cmd_if.sv
`timescale 1ns/1ps
interface cbo_cmd_if;
	logic start;
	logic busy;
	modport owner (output start, input busy);
	modport engine (input start, output busy);
endinterface

// File: rtl/cbo_cmd_timer.sv
`timescale 1ns/1ps
module cbo_cmd_timer #(
	parameter logic [15:0] CYCLES = 16'h0010
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_b,
	// Command
	cbo_cmd_if.engine cmd
);
	import cbo_pkg::*;

	cbo_cmd_state_t state_q;
	logic [15:0]    cnt_q;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= CBO_CMD_IDLE;
			cnt_q   <= 16'h0000;
		end else begin
			case (state_q)
				CBO_CMD_IDLE: begin
					if (cmd.start) begin
						state_q <= CBO_CMD_BUSY;
						cnt_q   <= CYCLES;
					end
				end
				CBO_CMD_BUSY: begin
					if (cnt_q <= 16'h0001)
						state_q <= CBO_CMD_IDLE;
					cnt_q <= cnt_q - 16'h0001;
				end
				default: state_q <= CBO_CMD_IDLE;
			endcase
		end
	end

	assign cmd.busy = (state_q == CBO_CMD_BUSY);
endmodule // cbo_cmd_timer

// File: rtl/cbo_regs.sv
`timescale 1ns/1ps
`include "cbo_map.svh"
module cbo_regs (
	// Clock and reset
	input  wire logic                mclk,
	input  wire logic                rst_b,
	// Register port
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	input  wire logic [7:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	output logic      [7:0]          reg_rdata,
	// Bank D control pins
	input  wire logic                pin_divider_select,
	input  wire logic                pin_source_select,
	input  wire logic                pin_powerdown,
	input  wire logic                pin_enable,
	input  wire logic                pin_style,
	input  wire logic [1:0]          pin_swing,
	// Clock sources for bank D
	input  wire logic                int_div_clk,
	input  wire logic                frac_div_clk,
	input  wire logic                ref_clk,
	// Bank outputs
	output logic      [2:0]          bank_abc_hold_low,
	output logic                     bank_d_clock,
	output logic                     bank_d_powered,
	output logic                     first_d_output_run,
	output logic                     first_d_output_style,
	output cbo_pkg::cbo_swing_t      first_d_output_swing,
	output logic                     second_d_output,
	output logic                     second_d_output_oe,
	output logic                     bank_d_config_owner,
	// Analog command strobes
	output logic                     divider_sync_busy,
	output logic                     pll_trigger_a,
	output logic                     bias_calibration_trigger
);
	import cbo_pkg::*;

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	logic [9:0] pin_s1_q;
	logic [9:0] pin_s2_q;
	logic [2:0] clk_s1_q;
	logic [2:0] clk_s2_q;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_q <= 10'h000;
			pin_s2_q <= 10'h000;
			clk_s1_q <= 3'h0;
			clk_s2_q <= 3'h0;
		end else begin
			pin_s1_q <= {pin_divider_select, pin_source_select, pin_powerdown,
				pin_enable, pin_style, pin_swing, 3'h0};
			pin_s2_q <= pin_s1_q;
			clk_s1_q <= {int_div_clk, frac_div_clk, ref_clk};
			clk_s2_q <= clk_s1_q;
		end
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	logic [3:0] enables_q;
	logic [7:0] bank_d_q;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			enables_q <= `CBO_RST_ENABLES;
		else if (reg_wr && hit(reg_addr, `CBO_OFF_ENABLES))
			enables_q <= reg_wdata[3:0];
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			bank_d_q <= `CBO_RST_BANKD;
		else if (reg_wr && hit(reg_addr, `CBO_OFF_BANKD))
			bank_d_q <= reg_wdata;
	end

	// ------------------------------------------------------------------------
	// Self-clearing commands
	// ------------------------------------------------------------------------
	cbo_cmd_if sync_if ();
	cbo_cmd_if pll_trigger_a_if ();
	cbo_cmd_if cal_if ();

	assign sync_if.start = reg_wr && hit(reg_addr, `CBO_OFF_SYNC)
		&& reg_wdata[`CBO_CMD_BIT];
	assign pll_trigger_a_if.start = reg_wr && hit(reg_addr, `CBO_OFF_PLL_TRIGGER_A)
		&& reg_wdata[`CBO_CMD_BIT];
	assign cal_if.start = reg_wr && hit(reg_addr, `CBO_OFF_BIASCAL)
		&& reg_wdata[`CBO_CMD_BIT];

	cbo_cmd_timer #(.CYCLES(`CBO_SYNC_CYC)) u_sync (
		.mclk  (mclk),
		.rst_b (rst_b),
		.cmd   (sync_if.engine)
	);
	cbo_cmd_timer #(.CYCLES(`CBO_PLL_TRIGGER_A_CYC)) u_pll_trigger_a (
		.mclk  (mclk),
		.rst_b (rst_b),
		.cmd   (pll_trigger_a_if.engine)
	);
	cbo_cmd_timer #(.CYCLES(`CBO_CAL_CYC)) u_cal (
		.mclk  (mclk),
		.rst_b (rst_b),
		.cmd   (cal_if.engine)
	);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			divider_sync_busy        <= 1'b0;
			pll_trigger_a            <= 1'b0;
			bias_calibration_trigger <= 1'b0;
		end else begin
			divider_sync_busy        <= sync_if.busy;
			pll_trigger_a            <= pll_trigger_a_if.busy;
			bias_calibration_trigger <= cal_if.busy;
		end
	end

	// ------------------------------------------------------------------------
	// Readback
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			reg_rdata <= 8'h00;
		else if (reg_rd) begin
			if (hit(reg_addr, `CBO_OFF_ENABLES))
				reg_rdata <= {4'h0, enables_q};
			else if (hit(reg_addr, `CBO_OFF_BANKD))
				reg_rdata <= bank_d_q;
			else
				reg_rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------------------
	// Effective bank D settings
	// ------------------------------------------------------------------------
	logic       own;
	logic       div_sel;
	logic       src_sel;
	logic       pd_bank;
	logic       pd_out;
	logic       en_d;
	logic       sty;
	logic [1:0] amp;
	logic       div_clk;
	logic       off;

	always_comb begin
		own = bank_d_q[`CBO_BD_OWN_BIT];
		if (own) begin
			div_sel = bank_d_q[`CBO_BD_DIV_BIT];
			src_sel = bank_d_q[`CBO_BD_SRC_BIT];
			pd_bank = bank_d_q[`CBO_BD_PD_BIT];
			en_d    = enables_q[`CBO_EN_D_BIT];
			sty     = bank_d_q[`CBO_BD_STY_BIT];
			amp     = bank_d_q[`CBO_BD_AMP_LO +: 2];
		end else begin
			div_sel = pin_s2_q[9];
			src_sel = pin_s2_q[8];
			pd_bank = pin_s2_q[7];
			en_d    = pin_s2_q[6];
			sty     = pin_s2_q[5];
			amp     = pin_s2_q[4:3];
		end
		pd_out  = bank_d_q[`CBO_BD_OPD_BIT];
		div_clk = div_sel ? clk_s2_q[1] : clk_s2_q[2];
		off     = pd_bank || pd_out;
	end

	// ------------------------------------------------------------------------
	// Output drive
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			bank_abc_hold_low    <= 3'h0;
			bank_d_clock         <= 1'b0;
			bank_d_powered       <= 1'b1;
			first_d_output_run   <= 1'b0;
			first_d_output_style <= 1'b0;
			first_d_output_swing <= CBO_SWING_350MV;
			second_d_output      <= 1'b0;
			second_d_output_oe   <= 1'b0;
			bank_d_config_owner  <= 1'b0;
		end else begin
			bank_abc_hold_low <= ~enables_q[3:1];
			bank_d_clock <= (src_sel ? clk_s2_q[0] : div_clk) && en_d
				&& !off;
			bank_d_powered       <= !pd_bank;
			first_d_output_run   <= en_d && !off;
			first_d_output_style <= sty;
			first_d_output_swing <= cbo_swing_t'(amp);
			second_d_output <= (src_sel ? clk_s2_q[0] : div_clk) && en_d
				&& !off;
			second_d_output_oe   <= !off;
			bank_d_config_owner  <= own;
		end
	end
endmodule // cbo_regs

// File: dv/cbo_host.sv
`timescale 1ns/1ps
module cbo_host (
	// Register bus
	input  wire logic       mclk,
	input  wire logic [7:0] reg_rdata,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata
);
	initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
	// Released data is inverted so a stale value is never mistaken for held.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		{reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge mclk);
		{reg_wr, reg_wdata} = {1'b0, ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk);
		{reg_rd, reg_addr} = {1'b1, a};
		@(negedge mclk);
		reg_rd = 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask
endmodule // cbo_host

// File: dv/cbo_regs_asserts.sv
`timescale 1ns/1ps
module cbo_regs_asserts (
	// Clock, reset and register port
	input wire logic                mclk,
	input wire logic                rst_b,
	input wire logic                reg_wr,
	input wire logic                reg_rd,
	input wire logic [7:0]          reg_addr,
	input wire logic [7:0]          reg_wdata,
	input wire logic [7:0]          reg_rdata,
	// Outputs
	input wire logic [2:0]          bank_abc_hold_low,
	input wire logic                bank_d_powered,
	input wire logic                first_d_output_run,
	input wire logic                first_d_output_style,
	input wire cbo_pkg::cbo_swing_t first_d_output_swing,
	input wire logic                second_d_output_oe,
	input wire logic                divider_sync_busy,
	input wire logic                pll_trigger_a,
	input wire logic                bias_calibration_trigger
);
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	logic [8:0] c_q [3];
	wire  [2:0] bz = {bias_calibration_trigger, pll_trigger_a,
		divider_sync_busy};
	// Counts how long each command has been running.
	always_ff @(posedge mclk or negedge rst_b) begin
		for (int i = 0; i < 3; i++) begin
			if (!rst_b) c_q[i] <= 9'h000;
			else c_q[i] <= bz[i] ? c_q[i] + 9'h001 : 9'h000;
		end
	end
	sync_len_a: assert property ($fell(divider_sync_busy) |->
		c_q[0] == 9'h010) else $error("sync length wrong");
	pll_trigger_a_len_a: assert property ($fell(pll_trigger_a) |->
		c_q[1] == 9'h100) else $error("pll_trigger_a length wrong");
	cal_len_a: assert property ($fell(bias_calibration_trigger) |->
		c_q[2] == 9'h040) else $error("calibration length wrong");
	sync_start_a: assert property (reg_wr && reg_addr == 8'h3d &&
		reg_wdata[7] && !divider_sync_busy |-> ##2 divider_sync_busy)
		else $error("sync did not start");
	cmd_read_zero_a: assert property (reg_rd && reg_addr != 8'h40 &&
		reg_addr != 8'h41 |=> reg_rdata == 8'h00)
		else $error("command or unmapped read not zero");
	abc_hold_a: assert property (reg_wr && reg_addr == 8'h40 |-> ##2
		bank_abc_hold_low == ~$past(reg_wdata[3:1], 2))
		else $error("bank hold wrong");
	bank_pd_a: assert property (reg_wr && reg_addr == 8'h41 &&
		reg_wdata[3:2] == 2'b11 |-> ##2 !bank_d_powered && !second_d_output_oe)
		else $error("bank power-down ignored");
	style_sw_a: assert property (reg_wr && reg_addr == 8'h41 &&
		reg_wdata[3] |-> ##2 first_d_output_style == $past(reg_wdata[5], 2)
		&& first_d_output_swing == $past(reg_wdata[7:6], 2))
		else $error("style or swing wrong");
endmodule // cbo_regs_asserts
bind cbo_regs cbo_regs_asserts cbo_regs_asserts_i (.mclk, .rst_b, .reg_wr,
	.reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .bank_abc_hold_low,
	.bank_d_powered, .first_d_output_run, .first_d_output_style,
	.first_d_output_swing, .second_d_output_oe, .divider_sync_busy,
	.pll_trigger_a, .bias_calibration_trigger);

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import cbo_pkg::*;
	logic        mclk, rst_b, reg_wr, reg_rd, clk_o, pwr, run, sty;
	logic        sec, oe, own, s_bz, p_bz, c_bz;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
	logic [6:0]  pins;
	logic [2:0]  hold;
	cbo_swing_t  swing;
	int          n_errors, comparisons, n;
	wire  [2:0]  bz = {c_bz, p_bz, s_bz};
	wire  [9:0]  outs = {hold, sty, swing, clk_o, pwr, run, oe};
	// Pins, bank D word, enables, expected outputs.
	logic [32:0] rows [10] = '{
		{7'h7f, 8'h28, 8'h0f, 10'h04f}, {7'h7f, 8'h09, 8'h0f, 10'h007},
		{7'h7f, 8'h0a, 8'h0f, 10'h007}, {7'h7f, 8'h18, 8'h0f, 10'h004},
		{7'h7f, 8'h9c, 8'h0f, 10'h020}, {7'h7f, 8'h08, 8'h06, 10'h205},
		{7'h7f, 8'h48, 8'h0f, 10'h01f}, {7'h0e, 8'h00, 8'h09, 10'h1ef},
		{7'h59, 8'h10, 8'h0f, 10'h010}, {7'h20, 8'h00, 8'h0f, 10'h005}};
	logic [15:0] rst_tab [6] = '{16'h400f, 16'h4100, 16'h3d00, 16'h3e00,
		16'h3f00, 16'h5500};
	logic [9:0]  len [3] = '{10'h010, 10'h100, 10'h040};
	cbo_regs cbo_regs_i (.mclk, .rst_b, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .pin_divider_select(pins[6]),
		.pin_source_select(pins[5]), .pin_powerdown(pins[4]),
		.pin_enable(pins[3]), .pin_style(pins[2]), .pin_swing(pins[1:0]),
		.int_div_clk(1'b1), .frac_div_clk(1'b0), .ref_clk(1'b0),
		.bank_abc_hold_low(hold), .bank_d_clock(clk_o), .bank_d_powered(pwr),
		.first_d_output_run(run), .first_d_output_style(sty),
		.first_d_output_swing(swing), .second_d_output(sec),
		.second_d_output_oe(oe), .bank_d_config_owner(own),
		.divider_sync_busy(s_bz), .pll_trigger_a(p_bz),
		.bias_calibration_trigger(c_bz));
	cbo_host cbo_host_i (.mclk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata);
	task automatic chk(input logic [9:0] s, input logic [9:0] e, string nm);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic report_and_stop();
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		#100000;
		n_errors++;
		report_and_stop();
	end
	initial begin
		{rst_b, pins} = 8'h7f;
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		rst_b = 1'b1;
		@(negedge mclk);
		chk({hold, pwr, oe}, 10'h003, "reset outputs");
		foreach (rst_tab[i]) begin
			cbo_host_i.rd(rst_tab[i][15:8], d);
			chk(10'(d), 10'(rst_tab[i][7:0]), "reset read");
		end
		foreach (rows[i]) begin
			pins = rows[i][32:26];
			cbo_host_i.wr(8'h41, rows[i][25:18]);
			cbo_host_i.wr(8'h40, rows[i][17:10]);
			repeat (3) @(negedge mclk);
			chk(outs, rows[i][9:0], "outputs");
			chk(10'({own, sec}), 10'({rows[i][21], rows[i][3]}), "own sec");
			cbo_host_i.rd(8'h41, d);
			chk(10'(d), 10'(rows[i][25:18]), "bank d");
			cbo_host_i.rd(8'h40, d);
			chk(10'(d), 10'(rows[i][17:10]), "enables");
		end
		for (int i = 0; i < 3; i++) begin
			cbo_host_i.wr(8'h3d + 8'(i), 8'h80);
			n = 0;
			repeat (10) if (bz[i] !== 1'b1) @(negedge mclk);
			while (bz[i] === 1'b1 && n < 400) begin
				n++;
				if (i == 0 && n == 4) begin
					cbo_host_i.wr(8'h3d, 8'h80);
					n++;
				end else @(negedge mclk);
			end
			chk(10'(n), len[i], "command length");
		end
		cbo_host_i.wr(8'h40, 8'h00);
		repeat (3) @(negedge mclk);
		chk(10'(hold), 10'h007, "hold");
		rst_b = 1'b0;
		repeat (2) @(negedge mclk);
		rst_b = 1'b1;
		cbo_host_i.rd(8'h40, d);
		chk(10'(d), 10'h00f, "second reset");
		report_and_stop();
	end
endmodule // tb_top
